// file: include/debug_port_defines.svh
// Constants of the debug port: offsets, fields, codes and reset values
`ifndef DEBUG_PORT_DEFINES_SVH
`define DEBUG_PORT_DEFINES_SVH
`define IR_RESET_VAL      5'h1F
`define IR_CAPTURE_VAL    5'h01
`define IR_DATA_CMD       5'h09
`define IR_BOOT_CMD       5'h0C
`define IR_QUICK_CMD      5'h0E
`define QUICK_LOW_ADDR    32'hFF200000
`define QUICK_HIGH_ADDR   32'hFF20000F
`define PROBE_DEBUG_VEC   32'hFF200200
`define NORMAL_DEBUG_VEC  32'hBFC00480
`define PROBE_SEG_BASE    32'hFF200000
`define PROBE_SEG_MASK    32'hFFE00000
`define CTRL_OFFSET       12'h000
`define ADDR_OFFSET       12'h004
`define DATA_OFFSET       12'h008
`define INSTR_OFFSET      12'h00C
`define CTRL_PEND_BIT     0
`define CTRL_DIR_BIT      1
`define CTRL_IRQ_BIT      4
`define CTRL_VEC_BIT      5
`define CTRL_SVC_BIT      6
`define CTRL_BOOT_BIT     7
`define CTRL_RST_BIT      8
`define DEBUG_BITS_RESET  1'b0
`define WORD_RESET        32'h00000000
`endif

// file: include/debug_port_pkg.sv
// Types shared by the debug port modules
package debug_port_pkg;
	typedef logic [31:0] word_t;
	typedef logic [4:0] instr_t;
	typedef enum logic [3:0] {
		TAP_RESET     = 4'h0,
		TAP_IDLE      = 4'h1,
		TAP_SEL_DR    = 4'h2,
		TAP_CAP_DR    = 4'h3,
		TAP_SHIFT_DR  = 4'h4,
		TAP_EXIT1_DR  = 4'h5,
		TAP_PAUSE_DR  = 4'h6,
		TAP_EXIT2_DR  = 4'h7,
		TAP_UPD_DR    = 4'h8,
		TAP_SEL_IR    = 4'h9,
		TAP_CAP_IR    = 4'hA,
		TAP_SHIFT_IR  = 4'hB,
		TAP_EXIT1_IR  = 4'hC,
		TAP_PAUSE_IR  = 4'hD,
		TAP_EXIT2_IR  = 4'hE,
		TAP_UPD_IR    = 4'hF
	} tap_state_e;
endpackage

// file: include/tap_if.sv
// Test port state and clock edges passed from the state machine
`timescale 1ns/1ps
interface tap_if;
	import debug_port_pkg::*;
	logic       tckRise;
	logic       tckFall;
	tap_state_e state;
	modport drive (output tckRise, output tckFall, output state);
	modport user (input tckRise, input tckFall, input state);
endinterface

// file: verilog/pin_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             clkEn,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else if (clkEn) begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;
endmodule

// file: verilog/tap_fsm.sv
// Test port state machine clocked by detected test clock edges
`timescale 1ns/1ps
module tap_fsm (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic clkEn,
	input  wire logic tckSync,
	input  wire logic tmsSync,
	tap_if.drive      tap
);
	import debug_port_pkg::*;

	logic       tckDly_reg;
	tap_state_e state_reg;
	tap_state_e state_next;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tckDly_reg <= 1'b0;
		end else if (clkEn) begin
			tckDly_reg <= tckSync;
		end
	end

	assign tap.tckRise = clkEn & tckSync & ~tckDly_reg;
	assign tap.tckFall = clkEn & ~tckSync & tckDly_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			TAP_RESET:    state_next = tmsSync ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     state_next = tmsSync ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   state_next = tmsSync ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   state_next = tmsSync ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: state_next = tmsSync ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: state_next = tmsSync ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: state_next = tmsSync ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: state_next = tmsSync ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:   state_next = tmsSync ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   state_next = tmsSync ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:   state_next = tmsSync ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: state_next = tmsSync ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: state_next = tmsSync ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: state_next = tmsSync ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: state_next = tmsSync ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR:   state_next = tmsSync ? TAP_SEL_DR : TAP_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= TAP_RESET;
		end else if (tap.tckRise) begin
			state_reg <= state_next;
		end
	end

	assign tap.state = state_reg;
endmodule

// file: verilog/debug_port_boot_qxfer.sv
// Debug test port with boot-to-debug command and quick transfer path
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "debug_port_defines.svh"
// Summary of operation
// - After boot command and reset, processor fetches from debug vector.
// - Three debug bits reset to one when boot indication active, else zero.
// - Debug interrupt request raised one cycle after processor reset ends.
// - Vector select set puts debug handler at 0xFF200200 in probe memory.
// - Probe service set stalls probe segment fetches until probe serves them.
// - Quick flag register is one bit; one bit in, one out per access.
// - Flag shifted in as zero requests completion; flag shifted out reports success.
// - Quick transfers legal only for 0xFF200000 through 0xFF20000F.
// - Processor stalls on quick area access with probe service set; pending bit held until done.
// - Upload: device shifts out word the processor is storing.
// - Success needs pending access and address inside legal quick area.
// - Upload is stores to probe segment; download is loads from it.
// - Quick command selects data and flag registers as one scan path.
// - Quick command decoded from instruction value 0x0E.
// - Boot command decoded from instruction value 0x0C.
// - Successful quick access clears pending bit, ending stall.
// - Writing zero to pending bit finishes access; writing one ignored.
module debug_port_boot_qxfer #(
	parameter int                  ADDR_W        = 12,
	parameter debug_port_pkg::word_t NORMAL_VECTOR = 32'h00000000
) (
	input  wire logic                  sys_clk,
	input  wire logic                  reset_n,
	input  wire logic                  clkEn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  tck,
	input  wire logic                  tms,
	input  wire logic                  tdi,
	output logic                       tdo,
	output logic                       tdoOe_n,
	input  wire logic                  cpuReset_n,
	input  wire logic                  cpuReq,
	input  wire logic                  cpuWrite,
	input  wire debug_port_pkg::word_t cpuAddr,
	input  wire debug_port_pkg::word_t cpuWdata,
	output debug_port_pkg::word_t      cpuRdata,
	output logic                       cpuDone,
	output logic                       cpuStall,
	input  wire logic                  dbgAck,
	output logic                       dbgIrqReq,
	output debug_port_pkg::word_t      fetchVector,
	output logic                       probeService
);
	import debug_port_pkg::*;

	function automatic logic inQuickArea(input word_t a);
		inQuickArea = (a >= `QUICK_LOW_ADDR) && (a <= `QUICK_HIGH_ADDR);
	endfunction

	function automatic logic inProbeSeg(input word_t a);
		inProbeSeg = (a & `PROBE_SEG_MASK) == `PROBE_SEG_BASE;
	endfunction

	logic [2:0] pinSync;
	logic       tckS;
	logic       tmsS;
	logic       tdiS;
	tap_if      tapBus();

	pin_sync #(
		.WIDTH (3)
	) u_sync (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.clkEn   (clkEn),
		.asyncIn ({tck, tms, tdi}),
		.syncOut (pinSync)
	);

	assign tckS = pinSync[2];
	assign tmsS = pinSync[1];
	assign tdiS = pinSync[0];

	tap_fsm u_tap (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.clkEn   (clkEn),
		.tckSync (tckS),
		.tmsSync (tmsS),
		.tap     (tapBus.drive)
	);

	logic   rise;
	logic   fall;
	logic   capDr;
	logic   shDr;
	logic   updDr;
	logic   capIr;
	logic   shIr;
	logic   updIr;
	logic   tlr;
	instr_t irShift_reg;
	instr_t ir_reg;
	logic   quickSel;
	logic   dataSel;
	logic   [32:0] dr_reg;
	logic   bootInd_reg;
	logic   pending_reg;
	logic   pendWrite_reg;
	word_t  pendAddr_reg;
	word_t  storeData_reg;
	word_t  loadData_reg;
	logic   cpuDone_reg;
	word_t  cpuRdata_reg;
	logic   dbgIrq_reg;
	logic   vecSel_reg;
	logic   probeSvc_reg;
	logic   cpuRstDly_reg;
	logic   dbgIrqOut_reg;
	word_t  fetchVec_reg;
	logic   tdo_reg;
	logic   tdoOeN_reg;
	word_t  prdata_reg;
	logic   pslverr_reg;
	logic   quickOk;
	logic   jtagDone;
	logic   apbSetup;
	logic   apbWr;
	logic   apbCtrlWr;
	logic   apbDone;
	logic   finishNow;
	logic   cpuAccept;
	logic   cpuNoSvc;
	logic   resetEnd;

	assign rise  = tapBus.tckRise;
	assign fall  = tapBus.tckFall;
	assign capDr = rise && tapBus.state == TAP_CAP_DR;
	assign shDr  = rise && tapBus.state == TAP_SHIFT_DR;
	assign updDr = rise && tapBus.state == TAP_UPD_DR;
	assign capIr = rise && tapBus.state == TAP_CAP_IR;
	assign shIr  = rise && tapBus.state == TAP_SHIFT_IR;
	assign updIr = rise && tapBus.state == TAP_UPD_IR;
	assign tlr   = rise && tapBus.state == TAP_RESET;

	assign quickSel = ir_reg == `IR_QUICK_CMD;
	assign dataSel  = ir_reg == `IR_DATA_CMD;

	// Instruction register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irShift_reg <= `IR_RESET_VAL;
			ir_reg      <= `IR_RESET_VAL;
		end else if (clkEn) begin
			if (tlr) begin
				ir_reg <= `IR_RESET_VAL;
			end else if (capIr) begin
				irShift_reg <= `IR_CAPTURE_VAL;
			end else if (shIr) begin
				irShift_reg <= {tdiS, irShift_reg[4:1]};
			end else if (updIr) begin
				ir_reg <= irShift_reg;
			end
		end
	end

	// Boot indication, consumed when a processor reset ends
	assign resetEnd = cpuReset_n & ~cpuRstDly_reg;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bootInd_reg <= 1'b0;
		end else if (clkEn) begin
			if (updIr && irShift_reg == `IR_BOOT_CMD) begin
				bootInd_reg <= 1'b1;
			end else if (resetEnd) begin
				bootInd_reg <= 1'b0;
			end
		end
	end

	// Quick access may succeed only with pending access in legal area
	assign quickOk  = pending_reg & inQuickArea(pendAddr_reg);
	assign jtagDone = updDr & quickSel & ~dr_reg[32] & quickOk;

	// Data scan path; quick command adds the flag bit at the input end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dr_reg <= '0;
		end else if (clkEn) begin
			if (capDr) begin
				if (quickSel) begin
					dr_reg <= {quickOk, storeData_reg};
				end else if (dataSel) begin
					dr_reg <= {1'b0, storeData_reg};
				end else begin
					dr_reg <= '0;
				end
			end else if (shDr) begin
				if (quickSel) begin
					dr_reg <= {tdiS, dr_reg[32:1]};
				end else if (dataSel) begin
					dr_reg <= {1'b0, tdiS, dr_reg[31:1]};
				end else begin
					dr_reg <= {32'h00000000, tdiS};
				end
			end
		end
	end

	// Load data for a pending processor read
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			loadData_reg <= `WORD_RESET;
		end else if (clkEn) begin
			if (updDr && (dataSel || quickSel)) begin
				loadData_reg <= dr_reg[31:0];
			end else if (apbWr && paddr == `DATA_OFFSET) begin
				loadData_reg <= pwdata;
			end
		end
	end

	// Test data out changes on the falling test clock edge
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tdo_reg    <= 1'b0;
			tdoOeN_reg <= 1'b1;
		end else if (clkEn && fall) begin
			tdo_reg <= (tapBus.state == TAP_SHIFT_IR) ? irShift_reg[0] : dr_reg[0];
			tdoOeN_reg <= !(tapBus.state == TAP_SHIFT_IR ||
				tapBus.state == TAP_SHIFT_DR);
		end
	end

	// APB decode
	assign apbSetup  = psel & ~penable;
	assign apbWr     = psel & penable & pwrite;
	assign apbCtrlWr = apbWr && paddr == `CTRL_OFFSET;
	assign apbDone   = apbCtrlWr & ~pwdata[`CTRL_PEND_BIT] & pending_reg;
	assign finishNow = jtagDone | apbDone;

	// Processor access handling
	assign cpuAccept = cpuReq & ~pending_reg & ~cpuDone_reg & cpuReset_n;
	assign cpuNoSvc  = cpuAccept & ~(inProbeSeg(cpuAddr) & probeSvc_reg);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pending_reg   <= 1'b0;
			pendWrite_reg <= 1'b0;
			pendAddr_reg  <= `WORD_RESET;
			storeData_reg <= `WORD_RESET;
		end else if (clkEn) begin
			if (!cpuReset_n) begin
				pending_reg <= 1'b0;
			end else if (cpuAccept && !cpuNoSvc) begin
				pending_reg   <= 1'b1;
				pendWrite_reg <= cpuWrite;
				pendAddr_reg  <= cpuAddr;
				storeData_reg <= cpuWrite ? cpuWdata : `WORD_RESET;
			end else if (finishNow) begin
				pending_reg <= 1'b0;
			end
		end
	end

	// Completion answer to the processor
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cpuDone_reg  <= 1'b0;
			cpuRdata_reg <= `WORD_RESET;
		end else if (clkEn) begin
			cpuDone_reg <= cpuNoSvc | finishNow;
			if (cpuNoSvc) begin
				cpuRdata_reg <= `WORD_RESET;
			end else if (jtagDone && !pendWrite_reg) begin
				cpuRdata_reg <= dr_reg[31:0];
			end else if (apbDone && !pendWrite_reg) begin
				cpuRdata_reg <= loadData_reg;
			end
		end
	end

	// Debug control bits load the boot indication during processor reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dbgIrq_reg   <= `DEBUG_BITS_RESET;
			vecSel_reg   <= `DEBUG_BITS_RESET;
			probeSvc_reg <= `DEBUG_BITS_RESET;
		end else if (clkEn) begin
			if (!cpuReset_n) begin
				dbgIrq_reg   <= bootInd_reg;
				vecSel_reg   <= bootInd_reg;
				probeSvc_reg <= bootInd_reg;
			end else begin
				if (apbCtrlWr && pwdata[`CTRL_IRQ_BIT]) begin
					dbgIrq_reg <= 1'b1;
				end else if (dbgAck) begin
					dbgIrq_reg <= 1'b0;
				end
				if (apbCtrlWr) begin
					vecSel_reg   <= pwdata[`CTRL_VEC_BIT];
					probeSvc_reg <= pwdata[`CTRL_SVC_BIT];
				end
			end
		end
	end

	// Processor side outputs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cpuRstDly_reg <= 1'b0;
			dbgIrqOut_reg <= 1'b0;
			fetchVec_reg  <= `WORD_RESET;
		end else if (clkEn) begin
			cpuRstDly_reg <= cpuReset_n;
			dbgIrqOut_reg <= dbgIrq_reg & cpuReset_n;
			if (!dbgIrq_reg) begin
				fetchVec_reg <= NORMAL_VECTOR;
			end else if (vecSel_reg) begin
				fetchVec_reg <= `PROBE_DEBUG_VEC;
			end else begin
				fetchVec_reg <= `NORMAL_DEBUG_VEC;
			end
		end
	end

	// APB read data and error, taken in the setup cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_reg  <= `WORD_RESET;
			pslverr_reg <= 1'b0;
		end else if (clkEn && apbSetup) begin
			prdata_reg  <= `WORD_RESET;
			pslverr_reg <= 1'b0;
			unique case (paddr)
				`CTRL_OFFSET: begin
					prdata_reg[`CTRL_PEND_BIT] <= pending_reg;
					prdata_reg[`CTRL_DIR_BIT]  <= pendWrite_reg;
					prdata_reg[`CTRL_IRQ_BIT]  <= dbgIrq_reg;
					prdata_reg[`CTRL_VEC_BIT]  <= vecSel_reg;
					prdata_reg[`CTRL_SVC_BIT]  <= probeSvc_reg;
					prdata_reg[`CTRL_BOOT_BIT] <= bootInd_reg;
					prdata_reg[`CTRL_RST_BIT]  <= ~cpuReset_n;
				end
				`ADDR_OFFSET: begin
					prdata_reg <= pendAddr_reg;
				end
				`DATA_OFFSET: begin
					prdata_reg <= storeData_reg;
				end
				`INSTR_OFFSET: begin
					prdata_reg <= {27'h0000000, ir_reg};
				end
				default: begin
					pslverr_reg <= 1'b1;
				end
			endcase
		end
	end

	assign prdata       = prdata_reg;
	assign pready       = 1'b1;
	assign pslverr      = pslverr_reg;
	assign tdo          = tdo_reg;
	assign tdoOe_n      = tdoOeN_reg;
	assign cpuRdata     = cpuRdata_reg;
	assign cpuDone      = cpuDone_reg;
	assign cpuStall     = pending_reg;
	assign dbgIrqReq    = dbgIrqOut_reg;
	assign fetchVector  = fetchVec_reg;
	assign probeService = probeSvc_reg;
endmodule

// file: test/debug_port_properties.sv
// Concurrent checks on the debug port top-level ports
`timescale 1ns/1ps
`include "debug_port_defines.svh"
module debug_port_properties #(
	parameter debug_port_pkg::word_t NORMAL_VECTOR = 32'h00000000
) (
	input wire logic                  sys_clk,
	input wire logic                  reset_n,
	input wire logic                  cpuReset_n,
	input wire logic                  cpuReq,
	input wire debug_port_pkg::word_t cpuAddr,
	input wire debug_port_pkg::word_t cpuRdata,
	input wire logic                  cpuDone,
	input wire logic                  cpuStall,
	input wire logic                  dbgAck,
	input wire logic                  dbgIrqReq,
	input wire debug_port_pkg::word_t fetchVector,
	input wire logic                  probeService
);
	import debug_port_pkg::*;
	logic taken;
	logic inSeg;
	assign taken = cpuReq && !cpuStall && !cpuDone && cpuReset_n;
	assign inSeg = (cpuAddr & `PROBE_SEG_MASK) == `PROBE_SEG_BASE;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_boot_end;
		$rose(cpuReset_n) ##1 dbgIrqReq;
	endsequence
	property p_bits_follow; $rose(cpuReset_n) |=> dbgIrqReq == probeService; endproperty
	property p_boot_vec; s_boot_end |-> fetchVector == `PROBE_DEBUG_VEC && probeService; endproperty
	property p_norm_vec; $past(cpuReset_n) && !dbgIrqReq |-> fetchVector == NORMAL_VECTOR; endproperty
	property p_ack_clr; dbgAck && cpuReset_n |=> ##1 !dbgIrqReq; endproperty
	property p_stall; taken && inSeg && probeService |=> cpuStall && !cpuDone; endproperty
	property p_pass; taken && (!inSeg || !probeService) |=> cpuDone && cpuRdata == '0; endproperty
	property p_end; $fell(cpuStall) && $past(cpuReset_n) |-> cpuDone; endproperty
	property p_pulse; cpuDone |=> !cpuDone; endproperty
	a_bits_follow: assert property (p_bits_follow)
		else $error("debug bits differ after reset");
	a_boot_vec: assert property (p_boot_vec)
		else $error("boot vector or service bit wrong");
	a_norm_vec: assert property (p_norm_vec)
		else $error("normal vector expected");
	a_ack_clr: assert property (p_ack_clr)
		else $error("debug request not cleared");
	a_stall: assert property (p_stall)
		else $error("probe segment access not stalled");
	a_pass: assert property (p_pass)
		else $error("unserviced access not answered");
	a_end: assert property (p_end)
		else $error("stall ended without done");
	a_pulse: assert property (p_pulse)
		else $error("done longer than one cycle");
endmodule
bind debug_port_boot_qxfer debug_port_properties #(.NORMAL_VECTOR(NORMAL_VECTOR))
	debug_port_properties_inst (.sys_clk, .reset_n, .cpuReset_n, .cpuReq, .cpuAddr,
	.cpuRdata, .cpuDone, .cpuStall, .dbgAck, .dbgIrqReq, .fetchVector, .probeService);

// file: test/probe_model.sv
// Probe model driving the serial test port
`timescale 1ns/1ps
module probe_model (
	input  wire logic sys_clk,
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdoOe_n
);
	logic o;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		o = 1'b0;
	end
	// One test clock period; clock rests low between frames
	task automatic pulse(input logic m, input logic v);
		@(posedge sys_clk);
		tms <= m;
		tdi <= v;
		repeat (16) @(posedge sys_clk);
		o = tdoOe_n ? ~o : tdo;
		tck <= 1'b1;
		repeat (16) @(posedge sys_clk);
		tck <= 1'b0;
	endtask
	task automatic scan(input logic ir, input int n, input logic [32:0] v,
			output logic [32:0] q);
		q = '0;
		pulse(1'b1, 1'b0);
		if (ir)
			pulse(1'b1, 1'b0);
		repeat (2) pulse(1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			pulse(i == n - 1, v[i]);
			q[i] = o;
		end
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b0);
	endtask
	task automatic reset_tap();
		repeat (5) pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b0);
	endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the boot and quick transfer debug port
`timescale 1ns/1ps
`include "debug_port_defines.svh"
`define CHK(a, b) begin \
	checked++; \
	if ((a) !== (b)) begin \
		bad_count++; \
		$display("Error t=%0t got %0h exp %0h", $time, (a), (b)); \
	end \
end
module tb_top;
	import debug_port_pkg::*;
	localparam word_t NV = 32'h00001000;
	logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic        tck, tms, tdi, tdo, tdoOe_n, cpuReset_n, cpuReq, cpuWrite, cpuDone;
	logic        cpuStall, dbgAck, dbgIrqReq, probeService, w, pend, ok;
	logic [11:0] paddr;
	logic [32:0] q;
	word_t       pwdata, prdata, r, d, x, a, cpuAddr, cpuWdata, cpuRdata, fetchVector;
	word_t       gotData;
	int          bad_count, checked, doneCnt, n0;
	debug_port_boot_qxfer #(.NORMAL_VECTOR(NV)) debug_port_boot_qxfer_inst (.sys_clk,
		.reset_n, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .tck, .tms, .tdi, .tdo, .tdoOe_n, .cpuReset_n, .cpuReq,
		.cpuWrite, .cpuAddr, .cpuWdata, .cpuRdata, .cpuDone, .cpuStall, .dbgAck,
		.dbgIrqReq, .fetchVector, .probeService);
	probe_model probe_model_inst (.sys_clk, .tck, .tms, .tdi, .tdo, .tdoOe_n);
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (cpuDone === 1'b1) begin
			cpuReq  <= 1'b0;
			gotData <= cpuRdata;
			doneCnt <= doneCnt + 1;
		end
	end
	function automatic logic legal(input word_t v);
		return v >= `QUICK_LOW_ADDR && v <= `QUICK_HIGH_ADDR;
	endfunction
	task automatic wrap_up();
		if (bad_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic fail();
		bad_count++;
		wrap_up();
	endtask
	task automatic apb(input logic wr, input logic [11:0] ad, input word_t wd);
		int n;
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= ad;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			fail();
	endtask
	task automatic cpu(input logic wr, input word_t ad, input word_t wd);
		@(posedge sys_clk);
		cpuReq   <= 1'b1;
		cpuWrite <= wr;
		cpuAddr  <= ad;
		cpuWdata <= wd;
	endtask
	task automatic waitdone(input int n);
		int k;
		for (k = 0; k < 400 && doneCnt != n; k++) @(posedge sys_clk);
		if (doneCnt != n)
			fail();
	endtask
	initial begin
		{psel, penable, pwrite, cpuReq, cpuWrite, dbgAck, reset_n, cpuReset_n} = '0;
		{paddr, pwdata, cpuAddr, cpuWdata} = '0;
		{bad_count, checked, doneCnt} = '0;
		void'($urandom(5491));
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		probe_model_inst.reset_tap();
		apb(1'b0, `CTRL_OFFSET, '0);
		`CHK(r, 32'h00000100)
		cpuReset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK({dbgIrqReq, probeService, fetchVector}, {2'b00, NV})
		probe_model_inst.scan(1'b1, 5, {28'h0, `IR_BOOT_CMD}, q);
		apb(1'b0, `CTRL_OFFSET, '0);
		`CHK(r[8:4], 5'h08)
		cpuReset_n <= 1'b0;
		apb(1'b0, `CTRL_OFFSET, '0);
		`CHK(r[8:4], 5'h1F)
		cpuReset_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		`CHK({dbgIrqReq, probeService, fetchVector}, {2'b11, `PROBE_DEBUG_VEC})
		cpu(1'b0, `PROBE_DEBUG_VEC, '0);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, `ADDR_OFFSET, '0);
		`CHK({cpuStall, r}, {1'b1, `PROBE_DEBUG_VEC})
		d = $urandom;
		apb(1'b1, `DATA_OFFSET, d);
		apb(1'b1, `CTRL_OFFSET, 32'h00000061);
		repeat (2) @(posedge sys_clk);
		`CHK(cpuStall, 1'b1)
		n0 = doneCnt;
		apb(1'b1, `CTRL_OFFSET, 32'h00000060);
		waitdone(n0 + 1);
		`CHK({cpuStall, gotData}, {1'b0, d})
		dbgAck <= 1'b1;
		@(posedge sys_clk);
		dbgAck <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK({dbgIrqReq, fetchVector}, {1'b0, NV})
		probe_model_inst.scan(1'b1, 5, {28'h0, `IR_QUICK_CMD}, q);
		for (int i = 0; i < 10; i++) begin
			w = $urandom;
			d = $urandom;
			x = $urandom;
			a = `QUICK_LOW_ADDR + ($urandom % 16);
			if (i < 3)
				a = (i == 0) ? `QUICK_LOW_ADDR : `QUICK_HIGH_ADDR + i - 1;
			pend = (i != 3);
			ok = pend && legal(a);
			n0 = doneCnt;
			if (pend)
				cpu(w, a, d);
			repeat (3) @(posedge sys_clk);
			`CHK(cpuStall, pend)
			probe_model_inst.scan(1'b0, 33, {i == 4, x}, q);
			`CHK(q[32], ok)
			if (ok && w)
				`CHK(q[31:0], d)
			if (ok && i != 4) begin
				waitdone(n0 + 1);
				`CHK(cpuStall, 1'b0)
				if (!w)
					`CHK(gotData, x)
			end else if (pend) begin
				`CHK(cpuStall, 1'b1)
				apb(1'b1, `CTRL_OFFSET, 32'h00000060);
				waitdone(n0 + 1);
			end
		end
		probe_model_inst.scan(1'b1, 5, {28'h0, `IR_DATA_CMD}, q);
		n0 = doneCnt;
		d = $urandom;
		cpu(1'b1, `QUICK_LOW_ADDR, d);
		repeat (3) @(posedge sys_clk);
		probe_model_inst.scan(1'b0, 32, {1'b0, ~d}, q);
		`CHK({cpuStall, q[31:0]}, {1'b1, d})
		apb(1'b1, `CTRL_OFFSET, 32'h00000060);
		waitdone(n0 + 1);
		n0 = doneCnt;
		cpu(1'b0, $urandom & 32'h7FFFFFFF, '0);
		waitdone(n0 + 1);
		`CHK({cpuStall, gotData}, 33'h0)
		apb(1'b1, `CTRL_OFFSET, 32'h00000020);
		n0 = doneCnt;
		cpu(1'b0, `QUICK_LOW_ADDR, '0);
		waitdone(n0 + 1);
		`CHK({cpuStall, gotData}, 33'h0)
		apb(1'b0, 12'h010, '0);
		`CHK(err, 1'b1)
		wrap_up();
	end
endmodule
